// [src/blc_exec.sv]
/*
 branch-to-link and signed-compare execution slice with an APB register file.
 software loads operands, then writes the instruction register; the
 instruction executes on the following clock and updates the registers.
 assumes: APB3 master on pclk, asynchronous active-low presetn.
*/
`include "blc_regs.svh"
`default_nettype none

module blc_exec #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb request
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	// apb answer
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [31:0] instr_ff;
	logic exec_ff;
	logic [31:0] loop_count_ff;
	logic [31:0] link_reg_ff;
	logic [31:0] condition_flags_ff;
	logic sticky_overflow_ff;
	logic [31:0] current_fetch_addr_ff;
	logic [31:0] next_fetch_addr_ff;
	logic [31:0] src_reg_a_ff;
	logic [31:0] src_reg_b_ff;
	blc_pkg::blc_status_t status_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	logic setup_phase;
	logic wr_en;
	logic mapped;
	logic [31:0] nxt_prdata;

	assign setup_phase = psel && !penable;
	assign wr_en = psel && penable && pready_ff && pwrite;

	always_comb begin
		mapped = 1'b1;
		nxt_prdata = `BLC_RST_WORD;
		case (paddr)
			`BLC_ADDR_INSTR: nxt_prdata = instr_ff;
			`BLC_ADDR_COUNT: nxt_prdata = loop_count_ff;
			`BLC_ADDR_LINK: nxt_prdata = link_reg_ff;
			`BLC_ADDR_COND: nxt_prdata = condition_flags_ff;
			`BLC_ADDR_OVF: nxt_prdata = {31'h0, sticky_overflow_ff};
			`BLC_ADDR_CUR: nxt_prdata = current_fetch_addr_ff;
			`BLC_ADDR_NEXT: nxt_prdata = next_fetch_addr_ff;
			`BLC_ADDR_SRCA: nxt_prdata = src_reg_a_ff;
			`BLC_ADDR_SRCB: nxt_prdata = src_reg_b_ff;
			`BLC_ADDR_STATUS: nxt_prdata = status_ff;
			default: mapped = 1'b0;
		endcase
	end

	// answer registered from the setup cycle: one access cycle, no wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= `BLC_RST_WORD;
		end else begin
			pready_ff <= setup_phase;
			pslverr_ff <= setup_phase && !mapped;
			if (setup_phase && !pwrite) begin
				prdata_ff <= nxt_prdata;
			end
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

	// ----------------------------------------
	// instruction issue
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_ff <= `BLC_RST_WORD;
			exec_ff <= 1'b0;
		end else begin
			exec_ff <= wr_en && (paddr == `BLC_ADDR_INSTR);
			if (wr_en && (paddr == `BLC_ADDR_INSTR)) begin
				instr_ff <= pwdata;
			end
		end
	end

	// ----------------------------------------
	// decode
	// ----------------------------------------
	blc_pkg::blc_bclr_t br;
	blc_pkg::blc_cmpi_t ci;
	blc_pkg::blc_cmp_t cr;
	logic is_bclr;
	logic is_cmp;
	logic is_cmpi;
	logic is_any_cmp;

	assign br = instr_ff;
	assign ci = instr_ff;
	assign cr = instr_ff;
	// link variants share decode with their base form
	assign is_bclr = exec_ff && br.opcd == `BLC_OP_BCLR && br.xo == `BLC_XO_BCLR;
	assign is_cmp = exec_ff && cr.opcd == `BLC_OP_CMP && cr.xo == `BLC_XO_CMP;
	assign is_cmpi = exec_ff && ci.opcd == `BLC_OP_CMPI;
	assign is_any_cmp = is_cmp || is_cmpi;

	// ----------------------------------------
	// branch evaluation
	// ----------------------------------------
	logic [31:0] ctr_after;
	logic [31:0] cr_shifted;
	logic ctr_ok;
	logic cond_ok;
	logic taken;
	logic [31:0] seq_addr;
	logic [31:0] target_addr;

	assign ctr_after = br.bo[`BLC_BO_NODEC] ? loop_count_ff
		: loop_count_ff - `BLC_ONE;
	// condition bit bi counts from the msb: field*4 + lt/gt/eq/so
	assign cr_shifted = condition_flags_ff << br.bi;
	assign ctr_ok = br.bo[`BLC_BO_NODEC]
		|| ((ctr_after == `BLC_RST_WORD) == br.bo[`BLC_BO_ZEROVAL]);
	assign cond_ok = br.bo[`BLC_BO_NOCOND]
		|| (cr_shifted[`BLC_MSB] == br.bo[`BLC_BO_CONDVAL]);
	assign taken = ctr_ok && cond_ok;
	assign seq_addr = current_fetch_addr_ff + `BLC_FETCH_STEP;
	// old link value, before this instruction's own save
	assign target_addr = link_reg_ff & `BLC_ALIGN_MASK;

	// ----------------------------------------
	// compare evaluation
	// ----------------------------------------
	logic [31:0] opnd_b;
	logic [3:0] cmp_bits;
	logic [31:0] field_mask;
	logic [31:0] cmp_cr;

	// constant form: sign-extended 16-bit operand
	assign opnd_b = is_cmpi ? 32'($signed(ci.imm)) : src_reg_b_ff;
	assign cmp_bits = {
		$signed(src_reg_a_ff) < $signed(opnd_b),
		$signed(src_reg_a_ff) > $signed(opnd_b),
		src_reg_a_ff == opnd_b,
		sticky_overflow_ff
	};
	// selector zero picks field 0, the leftmost nibble
	assign field_mask = `BLC_CR0_MASK >> {ci.bf, 2'b00};
	assign cmp_cr = (condition_flags_ff & ~field_mask)
		| ({`BLC_CR_FIELDS{cmp_bits}} & field_mask);

	// ----------------------------------------
	// architectural registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop_count_ff <= `BLC_RST_WORD;
		end else if (is_bclr) begin
			loop_count_ff <= ctr_after;
		end else if (wr_en && paddr == `BLC_ADDR_COUNT) begin
			loop_count_ff <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_reg_ff <= `BLC_RST_WORD;
		end else if (is_bclr && br.lk) begin
			link_reg_ff <= seq_addr;
		end else if (wr_en && paddr == `BLC_ADDR_LINK) begin
			link_reg_ff <= pwdata;
		end
	end

	// bit 31 of the register form is not checked; field 0 left as computed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			condition_flags_ff <= `BLC_RST_WORD;
		end else if (is_any_cmp) begin
			condition_flags_ff <= cmp_cr;
		end else if (wr_en && paddr == `BLC_ADDR_COND) begin
			condition_flags_ff <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sticky_overflow_ff <= 1'b0;
		end else if (wr_en && paddr == `BLC_ADDR_OVF) begin
			sticky_overflow_ff <= pwdata[0];
		end
	end

	// fetch address steps or jumps on every branch or compare; unknown opcodes leave it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			current_fetch_addr_ff <= `BLC_RST_WORD;
			next_fetch_addr_ff <= `BLC_RST_WORD;
		end else if (is_bclr) begin
			current_fetch_addr_ff <= taken ? target_addr : seq_addr;
			next_fetch_addr_ff <= taken ? target_addr : seq_addr;
		end else if (is_any_cmp) begin
			current_fetch_addr_ff <= seq_addr;
			next_fetch_addr_ff <= seq_addr;
		end else if (wr_en && paddr == `BLC_ADDR_CUR) begin
			current_fetch_addr_ff <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_reg_a_ff <= `BLC_RST_WORD;
			src_reg_b_ff <= `BLC_RST_WORD;
		end else if (wr_en) begin
			if (paddr == `BLC_ADDR_SRCA) begin
				src_reg_a_ff <= pwdata;
			end
			if (paddr == `BLC_ADDR_SRCB) begin
				src_reg_b_ff <= pwdata;
			end
		end
	end

	// status describes the last executed instruction only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_ff <= '0;
		end else if (exec_ff) begin
			status_ff.taken <= is_bclr && taken;
			status_ff.bad_form <= is_any_cmp && ci.size_sel;
			status_ff.unknown_op <= !(is_bclr || is_any_cmp);
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	ctr_dec_a: assert property (
		is_bclr && !br.bo[`BLC_BO_NODEC] |=> loop_count_ff == $past(loop_count_ff) - `BLC_ONE
	) else $error("counter not decremented");

	ctr_hold_a: assert property (
		is_bclr && br.bo[`BLC_BO_NODEC] |=> $stable(loop_count_ff)
	) else $error("counter changed without decrement");

	uncond_take_a: assert property (
		is_bclr && br.bo == `BLC_BO_ALWAYS |=> status_ff.taken && $stable(loop_count_ff)
	) else $error("unconditional branch not taken");

	dnz_taken_a: assert property (
		is_bclr && br.bo == `BLC_BO_DNZ && loop_count_ff != `BLC_ONE |=> status_ff.taken
	) else $error("nonzero count branch missed");

	dz_taken_a: assert property (
		is_bclr && br.bo == `BLC_BO_DZ |=> status_ff.taken == ($past(loop_count_ff) == `BLC_ONE)
	) else $error("zero count branch wrong");

	target_old_a: assert property (
		is_bclr && taken |=> next_fetch_addr_ff == ($past(link_reg_ff) & `BLC_ALIGN_MASK)
	) else $error("taken target wrong");

	seq_fetch_a: assert property (
		is_bclr && !taken |=> next_fetch_addr_ff == $past(current_fetch_addr_ff) + `BLC_FETCH_STEP
	) else $error("fall-through address wrong");

	link_save_a: assert property (
		is_bclr && br.lk |=> link_reg_ff == $past(current_fetch_addr_ff) + `BLC_FETCH_STEP
	) else $error("link not saved");

	field_only_a: assert property (
		is_any_cmp |=> ((condition_flags_ff ^ $past(condition_flags_ff)) & ~$past(field_mask)) == '0
	) else $error("other condition field altered");

	ovf_copy_a: assert property (
		is_any_cmp ##1 1'b1 |-> (condition_flags_ff & $past(field_mask) & `BLC_OVF_BITS)
			== ($past(sticky_overflow_ff) ? $past(field_mask) & `BLC_OVF_BITS : '0)
	) else $error("overflow copy wrong");

	signed_lt_a: assert property (
		is_cmp && $signed(src_reg_a_ff) < $signed(src_reg_b_ff)
			|=> (condition_flags_ff & $past(field_mask) & `BLC_LT_BITS) != '0
	) else $error("signed less-than lost");

	apb_answer_a: assert property (
		setup_phase |=> pready_ff
	) else $error("no answer after setup");

	taken_link_c: cover property (is_bclr && taken && br.lk);
	loop_exit_c: cover property (is_bclr && br.bo == `BLC_BO_DZ && taken);
	cmpi_neg_c: cover property (is_cmpi && ci.imm[15] && ci.bf != '0);
	unmapped_c: cover property (setup_phase && !mapped);

endmodule // blc_exec

`default_nettype wire

// [src/blc_regs.svh]
/*
 register offsets, instruction encodings, field positions and reset values
 for the branch-to-link and signed-compare execution block.
 assumes: included by bare name from the design files.
*/
`ifndef BLC_REGS_SVH
`define BLC_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define BLC_ADDR_INSTR 8'h00
`define BLC_ADDR_COUNT 8'h04
`define BLC_ADDR_LINK 8'h08
`define BLC_ADDR_COND 8'h0c
`define BLC_ADDR_OVF 8'h10
`define BLC_ADDR_CUR 8'h14
`define BLC_ADDR_NEXT 8'h18
`define BLC_ADDR_SRCA 8'h1c
`define BLC_ADDR_SRCB 8'h20
`define BLC_ADDR_STATUS 8'h24

// ----------------------------------------
// encodings
// ----------------------------------------
`define BLC_OP_BCLR 6'h13
`define BLC_XO_BCLR 10'h010
`define BLC_OP_CMP 6'h1f
`define BLC_XO_CMP 10'h000
`define BLC_OP_CMPI 6'h0b
`define BLC_BO_ALWAYS 5'h14
`define BLC_BO_DNZ 5'h10
`define BLC_BO_DZ 5'h12

// ----------------------------------------
// option bit positions and field geometry
// ----------------------------------------
`define BLC_BO_NOCOND 4
`define BLC_BO_CONDVAL 3
`define BLC_BO_NODEC 2
`define BLC_BO_ZEROVAL 1
`define BLC_MSB 31
`define BLC_CR_FIELDS 8
`define BLC_CR0_MASK 32'hf000_0000
`define BLC_OVF_BITS 32'h1111_1111
`define BLC_LT_BITS 32'h8888_8888
`define BLC_ALIGN_MASK 32'hffff_fffc

// ----------------------------------------
// constants and reset values
// ----------------------------------------
`define BLC_FETCH_STEP 32'h0000_0004
`define BLC_ONE 32'h0000_0001
`define BLC_RST_WORD 32'h0000_0000

`endif

// [src/blc_pkg.sv]
/*
 types shared by the execution block: instruction layouts and status word.
 assumes: nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package blc_pkg;

	// ----------------------------------------
	// instruction layouts
	// ----------------------------------------
	typedef struct packed {
		logic [5:0] opcd;
		logic [4:0] bo;
		logic [4:0] bi;
		logic [4:0] rsv;
		logic [9:0] xo;
		logic lk;
	} blc_bclr_t;

	typedef struct packed {
		logic [5:0] opcd;
		logic [2:0] bf;
		logic rsv;
		logic size_sel;
		logic [4:0] ra;
		logic [15:0] imm;
	} blc_cmpi_t;

	typedef struct packed {
		logic [5:0] opcd;
		logic [2:0] bf;
		logic rsv;
		logic size_sel;
		logic [4:0] ra;
		logic [4:0] rb;
		logic [9:0] xo;
		logic low_bit;
	} blc_cmp_t;

	// ----------------------------------------
	// status word
	// ----------------------------------------
	typedef struct packed {
		logic [28:0] rsv;
		logic unknown_op;
		logic bad_form;
		logic taken;
	} blc_status_t;

endpackage

`default_nettype wire

// [verif/testbench.sv]
/*
 self-checking bench for the branch-to-link and signed-compare slice.
 assumes: blc_regs.svh on the include path, blc_pkg and blc_exec compiled first.
*/
`include "blc_regs.svh"
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------
	// clock, reset and apb signals
	// ----------------------------------------
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	int n_errors = 0;
	int tests_run = 0;
	logic [31:0] seed = 32'h2aee64ed;
	logic [31:0] r, x, ctr, nctr, lr, cr, current_fetch_addr, a, b, cr_exp, instr;
	logic [15:0] imm;
	logic [4:0] bo, bi;
	logic [2:0] bf;
	logic [3:0] f;
	logic e, lk, tk, sz, ovf, cm;
	logic [4:0] bo_tab [9] = '{5'h14, 5'h10, 5'h00, 5'h08, 5'h12, 5'h02, 5'h0a, 5'h0c, 5'h04};

	always #50 pclk = ~pclk;

	blc_exec #(.ADDR_W(8)) u_blc_exec (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function logic exp_taken(input logic [4:0] o, input logic [31:0] c, input logic [31:0] fl,
		input logic [4:0] sel);
		logic [31:0] cn;
		cn = o[2] ? c : c - 32'h0000_0001;
		return (o[2] | ((cn == 32'h0000_0000) == o[1])) & (o[4] | (fl[5'h1f - sel] == o[3]));
	endfunction

	task end_sim();
		$display("mismatches %0d comparisons %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
			n_errors++;
		end
	endtask

	// one apb transfer, entered just after a rising edge
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			$display("unexpected at %0t: no pready", $time);
			n_errors++;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task wr(input logic [7:0] ad, input logic [31:0] d);
		logic [31:0] rd;
		logic er;
		apb(1'b1, ad, d, rd, er);
	endtask

	task rdchk(input logic [7:0] ad, input logic [31:0] exp, input string what);
		logic [31:0] rd;
		logic er;
		apb(1'b0, ad, 32'h0000_0000, rd, er);
		chk(rd, exp, what);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 1; i < 10; i++) begin
			rdchk(8'(4 * i), 32'h0000_0000, "reset value");
		end
		$display("test reset done");
		// option table
		for (int t = 0; t < 9; t++) begin
			for (int k = 0; k < 4; k++) begin
				bo = bo_tab[t];
				ctr = (k == 0) ? 32'h0000_0001 : (k == 1) ? 32'h0000_0000 : (k == 2) ? 32'h0000_0002 : rnd();
				lr = rnd();
				cr = rnd();
				current_fetch_addr = rnd() & `BLC_ALIGN_MASK;
				x = rnd();
				bi = x[4:0];
				lk = x[5];
				wr(`BLC_ADDR_COUNT, ctr);
				wr(`BLC_ADDR_LINK, lr);
				wr(`BLC_ADDR_COND, cr);
				wr(`BLC_ADDR_CUR, current_fetch_addr);
				wr(`BLC_ADDR_INSTR, {`BLC_OP_BCLR, bo, bi, 5'h00, `BLC_XO_BCLR, lk});
				nctr = bo[2] ? ctr : ctr - 32'h0000_0001;
				tk = exp_taken(bo, ctr, cr, bi);
				r = tk ? (lr & `BLC_ALIGN_MASK) : current_fetch_addr + 32'h0000_0004;
				rdchk(`BLC_ADDR_COUNT, nctr, "counter");
				rdchk(`BLC_ADDR_NEXT, r, "next");
				rdchk(`BLC_ADDR_CUR, r, "current");
				rdchk(`BLC_ADDR_LINK, lk ? current_fetch_addr + 4 : lr, "link");
				rdchk(`BLC_ADDR_STATUS, {31'h0, tk}, "taken");
			end
		end
		$display("test branch done");
		for (int i = 0; i < 24; i++) begin
			x = rnd();
			a = rnd();
			b = rnd();
			imm = b[15:0];
			if (i == 0) begin
				a = 32'h8000_0000;
				b = 32'h0000_0001;
			end
			if (i == 1 || i == 4) begin
				a = {{16{imm[15]}}, imm};
				b = a;
			end
			if (i == 2) begin
				a = 32'h0000_0001;
				b = 32'hffff_ffff;
			end
			if (i == 3) begin
				a = 32'h0000_0000;
				imm = 16'h8000;
			end
			cm = i[0];
			bf = (i < 4) ? 3'h0 : x[2:0];
			sz = (i == 6);
			ovf = x[3];
			cr = rnd();
			current_fetch_addr = rnd() & `BLC_ALIGN_MASK;
			if (cm) begin
				b = {{16{imm[15]}}, imm};
				instr = {`BLC_OP_CMPI, bf, 1'b0, sz, 5'h00, imm};
			end else begin
				instr = {`BLC_OP_CMP, bf, 1'b0, sz, 5'h00, 5'h00, `BLC_XO_CMP, 1'b0};
			end
			wr(`BLC_ADDR_SRCA, a);
			wr(`BLC_ADDR_SRCB, rnd() ^ {32{cm}} ^ (b & {32{~cm}}) ^ (rnd() & 32'h0000_0000));
			if (!cm) begin
				wr(`BLC_ADDR_SRCB, b);
			end
			wr(`BLC_ADDR_OVF, {31'h0, ovf});
			wr(`BLC_ADDR_COND, cr);
			wr(`BLC_ADDR_CUR, current_fetch_addr);
			wr(`BLC_ADDR_INSTR, instr);
			f = {$signed(a) < $signed(b), $signed(a) > $signed(b), a == b, ovf};
			cr_exp = cr;
			cr_exp[31 - 4 * bf -: 4] = f;
			rdchk(`BLC_ADDR_COND, cr_exp, "compare field");
			rdchk(`BLC_ADDR_STATUS, {29'h0, 1'b0, sz, 1'b0}, "compare status");
		end
		$display("test compare done");
		apb(1'b0, 8'h28, 32'h0000_0000, r, e);
		chk({31'h0, e}, 32'h0000_0001, "unmapped error");
		chk(r, 32'h0000_0000, "unmapped data");
		wr(`BLC_ADDR_INSTR, 32'h0000_0000);
		rdchk(`BLC_ADDR_STATUS, 32'h0000_0004, "unknown op status");
		apb(1'b0, `BLC_ADDR_NEXT, 32'h0000_0000, r, e);
		wr(`BLC_ADDR_NEXT, ~r);
		rdchk(`BLC_ADDR_NEXT, r, "read-only next");
		$display("test access done");
		end_sim();
	end

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge pclk);
		$display("unexpected at %0t: run too long", $time);
		n_errors++;
		end_sim();
	end

endmodule // testbench

`default_nettype wire
